// file: csb_map.vh
// Constants shared by the channel status block buffer design.
// Assumes nothing of its surroundings; definitions only.
`ifndef CSB_MAP_VH
`define CSB_MAP_VH

// Register port address width and data width.
`define CSB_ADDR_W        7
`define CSB_DATA_W        8

// Host-side buffer window: 24 words of A byte then B byte.
`define CSB_EBUF_BASE     7'h20
`define CSB_EBUF_END      7'h50
`define CSB_BLOCK_BYTES   24
`define CSB_LAST_BYTE     5'h17

// Control and status registers.
`define CSB_CTRL_ADDR     7'h12
`define CSB_STAT_ADDR     7'h13
`define CSB_CTRL_INHIBIT  0
`define CSB_CTRL_EVT_EN   1
`define CSB_STAT_EVENT    0
`define CSB_STAT_FIFO_MT  1
`define CSB_CTRL_RESET    8'h00

// Subframes per block (192 frames of A and B) and last index.
`define CSB_SUBFRAMES     9'h180
`define CSB_LAST_SUB      9'h17f

// External sync must stay high this many clocks to be honoured.
`define CSB_SYNC_MIN      2'h3

// Check byte polynomial and preset.
`define CSB_CRC_POLY      8'h1d
`define CSB_CRC_INIT      8'hff

// Write queue depth.
`define CSB_FIFO_DEPTH    8

`endif

// file: csb_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module csb_fifo #(
    parameter WIDTH = 15,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output reg              inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words.
    reg [AW-1:0]    wrPtr_reg;         // Next slot to fill.
    reg [AW-1:0]    rdPtr_reg;         // Next slot to drain.
    reg [AW:0]      count_reg;         // Words held.
    wire            doPush;            // Word accepted this cycle.
    wire            doPop;             // Word removed this cycle.
    wire [AW:0]     count_next;        // Occupancy after this cycle.

    assign doPush     = inValid && inReady;
    assign doPop      = outValid && outReady;
    assign outValid   = (count_reg != {(AW+1){1'b0}});
    assign outData    = mem[rdPtr_reg];
    assign count_next = count_reg + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};

    ////////////////////////////////////////////////////////////////////////////
    // Pointers, occupancy and a registered ready, so the filling side sees
    // full honestly one cycle after the last slot is taken.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            inReady   <= 1'b1;
        end
        else
        begin
            if (doPush)
            begin
                wrPtr_reg <= (wrPtr_reg == DEPTH - 1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
            end
            if (doPop)
            begin
                rdPtr_reg <= (rdPtr_reg == DEPTH - 1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
            end
            count_reg <= count_next;
            inReady   <= (count_next < DEPTH);
        end
    end

    // Storage is written without reset; only occupied slots are ever read.
    always @(posedge core_clk)
    begin
        if (doPush)
        begin
            mem[wrPtr_reg] <= inData;
        end
    end

endmodule // csb_fifo

`default_nettype wire

// file: csb_block_buffer.v
// Channel status block buffer: host-side buffer, transmit-side buffer,
// block transfers with check byte, and block-start sync pin handling.
// Assumes subframeStrobe comes from transmitter logic on core_clk and that
// subframes are more than 30 clocks apart.
//
// Notes on behaviour
// - Sync pin aligns outputs at block boundaries.
// - Hold 384 status bits; user bits excluded.
// - Status handled in whole, resynchronised blocks.
// - Two cascaded block buffers, host then transmit.
// - Byte MSB is the earliest bit sent.
// - Byte zero at 20h, MSB is pro flag.
// - Host reads and writes the host-side buffer.
// - Transmit buffer alone feeds serial status bits.
// - Each transfer sets event, enable gates interrupt.
// - Inhibit bit blocks all buffer transfers.
// - Pro block gets check byte generated automatically.
// - Check byte also for serially entered status.
// - Driven sync high through first subframe only.
// - 24 words, A upper byte, B lower byte.
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.vh"

module csb_block_buffer #(
    parameter FIFO_DEPTH = `CSB_FIFO_DEPTH
) (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire [6:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrite,
    output wire       regWrReady,
    input  wire       regRead,
    output reg  [7:0] regRdData,
    output reg        regRdValid,
    input  wire       subframeStrobe,
    output reg        txStatusBit,
    output reg        txStatusBitIsB,
    output reg        xferIrq,
    input  wire       block_start_sync_direction,
    input  wire       blockStartSyncIn,
    output reg        blockStartSyncOut,
    output reg        blockStartSyncOe,
    input  wire       pinConfigMode,
    input  wire       serialStatusIn
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // One byte through the check polynomial, MSB first as transmitted.
    function [7:0] crc_byte;
        input [7:0] crcIn;
        input [7:0] dataIn;
        integer     i;
        reg   [7:0] c;
        begin
            c = crcIn;
            for (i = 7; i >= 0; i = i - 1)
            begin
                c = (c[7] ^ dataIn[i]) ? ({c[6:0], 1'b0} ^ `CSB_CRC_POLY) : {c[6:0], 1'b0};
            end
            crc_byte = c;
        end
    endfunction

    // True when an address falls inside the host-side buffer window.
    function is_ebuf;
        input [6:0] a;
        begin
            is_ebuf = (a >= `CSB_EBUF_BASE) && (a < `CSB_EBUF_END);
        end
    endfunction

    // Word index of a buffer address; bit 0 of the address picks the lane.
    function [4:0] ebuf_word;
        input [6:0] a;
        reg   [6:0] d;
        begin
            d = a - `CSB_EBUF_BASE;
            ebuf_word = d[5:1];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    reg  [7:0]  eBufA [0:23];        // Host-side buffer, channel A lane.
    reg  [7:0]  eBufB [0:23];        // Host-side buffer, channel B lane.
    reg  [7:0]  fBufA [0:23];        // Transmit-side buffer, channel A.
    reg  [7:0]  fBufB [0:23];        // Transmit-side buffer, channel B.
    reg  [7:0]  ctrl_reg;            // Inhibit and event enable.
    reg         event_reg;           // Sticky transfer event.
    reg  [8:0]  subCount_reg;        // Subframe position inside the block.
    reg         xferActive_reg;      // Transfer engine running.
    reg  [4:0]  xferIdx_reg;         // Byte being copied.
    reg  [7:0]  crcA_reg;            // Running check byte, channel A.
    reg  [7:0]  crcB_reg;            // Running check byte, channel B.
    reg  [1:0]  syncHigh_reg;        // Clocks the sync input has been high.
    reg         syncPending_reg;     // External block restart armed.
    reg  [1:0]  dirSync_reg;         // Direction strap synchroniser.
    reg  [1:0]  syncInSync_reg;      // Sync input synchroniser.
    reg  [1:0]  modeSync_reg;        // Pin mode synchroniser.
    reg  [1:0]  serSync_reg;         // Serial status synchroniser.
    wire [14:0] qData;               // Queued write: address and data.
    wire        qValid;              // Queued write available.
    wire        serialWrite;         // Serial bit lands in buffer now.
    wire        qReady;              // Drain the queue this cycle.
    wire        restart;             // This strobe opens a new block.
    wire [8:0]  curSub;              // Subframe index of this strobe.
    wire [7:0]  frameIdx;            // Frame number inside the block.
    wire [4:0]  bitByte;             // Byte holding the current bit.
    wire [2:0]  bitPos;              // Bit position, MSB sent first.
    wire [4:0]  rdWord;              // Word index for reads.
    wire [4:0]  qWord;               // Word index for queued writes.

    assign restart     = syncPending_reg && !dirSync_reg[1];
    assign curSub      = restart ? 9'h000 : subCount_reg;
    assign frameIdx    = curSub[8:1];
    assign bitByte     = frameIdx[7:3];
    assign bitPos      = 3'h7 - frameIdx[2:0];
    assign serialWrite = modeSync_reg[1] && subframeStrobe;
    assign qReady      = !xferActive_reg && !serialWrite;
    assign rdWord      = ebuf_word(regAddr);
    assign qWord       = ebuf_word(qData[14:8]);

    ////////////////////////////////////////////////////////////////////////////
    // Host writes queue here; a full queue pushes back on the host.
    csb_fifo #(
        .WIDTH    (15),
        .DEPTH    (FIFO_DEPTH),
        .AW       (3)
    ) u_wr_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inData   ({regAddr, regWrData}),
        .inValid  (regWrite),
        .inReady  (regWrReady),
        .outData  (qData),
        .outValid (qValid),
        .outReady (qReady)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; every pin passes two flops before use.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            dirSync_reg    <= 2'h0;
            syncInSync_reg <= 2'h0;
            modeSync_reg   <= 2'h0;
            serSync_reg    <= 2'h0;
        end
        else
        begin
            dirSync_reg    <= {dirSync_reg[0], block_start_sync_direction};
            syncInSync_reg <= {syncInSync_reg[0], blockStartSyncIn};
            modeSync_reg   <= {modeSync_reg[0], pinConfigMode};
            serSync_reg    <= {serSync_reg[0], serialStatusIn};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host-side buffer: queued host writes, or serial bits in pin mode.
    // Reset clears it so an untouched block goes out as all zeros.
    always @(posedge core_clk)
    begin : ebuf_write
        integer k;
        if (!rst_n)
        begin
            for (k = 0; k < `CSB_BLOCK_BYTES; k = k + 1)
            begin
                eBufA[k] <= 8'h00;
                eBufB[k] <= 8'h00;
            end
        end
        else if (serialWrite)
        begin
            // Serial bits fill the buffer in send order.
            if (curSub[0])
            begin
                eBufB[bitByte][bitPos] <= serSync_reg[1];
            end
            else
            begin
                eBufA[bitByte][bitPos] <= serSync_reg[1];
            end
        end
        else if (qValid && qReady && is_ebuf(qData[14:8]))
        begin
            // Even address is the A byte, odd the B byte.
            if (qData[8])
            begin
                eBufB[qWord] <= qData[7:0];
            end
            else
            begin
                eBufA[qWord] <= qData[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and status. A transfer finishing in the cycle of a clear wins.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl_reg  <= `CSB_CTRL_RESET;
            event_reg <= 1'b0;
            xferIrq   <= 1'b0;
        end
        else
        begin
            if (qValid && qReady && qData[14:8] == `CSB_CTRL_ADDR)
            begin
                ctrl_reg <= qData[7:0];
            end
            if (xferActive_reg && xferIdx_reg == `CSB_LAST_BYTE)
            begin
                event_reg <= 1'b1;
            end
            else if (qValid && qReady && qData[14:8] == `CSB_STAT_ADDR
                     && qData[`CSB_STAT_EVENT])
            begin
                event_reg <= 1'b0;
            end
            xferIrq <= event_reg && ctrl_reg[`CSB_CTRL_EVT_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads answer one cycle after the strobe.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead;
            if (!regRead)
            begin
                regRdData <= 8'h00;
            end
            else if (is_ebuf(regAddr))
            begin
                regRdData <= regAddr[0] ? eBufB[rdWord] : eBufA[rdWord];
            end
            else if (regAddr == `CSB_CTRL_ADDR)
            begin
                regRdData <= ctrl_reg;
            end
            else if (regAddr == `CSB_STAT_ADDR)
            begin
                regRdData <= {6'h00, !qValid, event_reg};
            end
            else
            begin
                // Unmapped addresses read as zero.
                regRdData <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Subframe position, external restart and the driven sync pin.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            subCount_reg      <= 9'h000;
            syncHigh_reg      <= 2'h0;
            syncPending_reg   <= 1'b0;
            blockStartSyncOut <= 1'b0;
            blockStartSyncOe  <= 1'b0;
        end
        else
        begin
            blockStartSyncOe <= dirSync_reg[1];
            // Count high clocks; three or more arm a restart.
            if (!syncInSync_reg[1] || dirSync_reg[1])
            begin
                syncHigh_reg <= 2'h0;
            end
            else if (syncHigh_reg != `CSB_SYNC_MIN)
            begin
                syncHigh_reg <= syncHigh_reg + 2'h1;
            end
            if (subframeStrobe)
            begin
                syncPending_reg <= 1'b0;
            end
            else if (syncHigh_reg == `CSB_SYNC_MIN && !dirSync_reg[1])
            begin
                syncPending_reg <= 1'b1;
            end
            if (subframeStrobe)
            begin
                subCount_reg <= (curSub == `CSB_LAST_SUB) ? 9'h000 : curSub + 9'h001;
                // High for the whole first subframe only.
                blockStartSyncOut <= dirSync_reg[1] && (curSub == 9'h000);
            end
            else if (!dirSync_reg[1])
            begin
                blockStartSyncOut <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial status bit for each subframe comes from the transmit buffer.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            txStatusBit    <= 1'b0;
            txStatusBitIsB <= 1'b0;
        end
        else if (subframeStrobe)
        begin
            txStatusBitIsB <= curSub[0];
            txStatusBit    <= curSub[0] ? fBufB[bitByte][bitPos]
                                        : fBufA[bitByte][bitPos];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine: starts once the last subframe of a block is taken, so
    // the next block opens on fresh contents and none is ever mixed. A sync
    // restart mid-block sends the rest of the old block from its start; that
    // trade keeps the copy tied to one boundary only.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            xferActive_reg <= 1'b0;
            xferIdx_reg    <= 5'h00;
            crcA_reg       <= `CSB_CRC_INIT;
            crcB_reg       <= `CSB_CRC_INIT;
        end
        else if (!xferActive_reg)
        begin
            xferIdx_reg <= 5'h00;
            crcA_reg    <= `CSB_CRC_INIT;
            crcB_reg    <= `CSB_CRC_INIT;
            if (subframeStrobe && curSub == `CSB_LAST_SUB
                && !ctrl_reg[`CSB_CTRL_INHIBIT])
            begin
                xferActive_reg <= 1'b1;
            end
        end
        else
        begin
            crcA_reg    <= crc_byte(crcA_reg, eBufA[xferIdx_reg]);
            crcB_reg    <= crc_byte(crcB_reg, eBufB[xferIdx_reg]);
            xferIdx_reg <= xferIdx_reg + 5'h01;
            if (xferIdx_reg == `CSB_LAST_BYTE)
            begin
                xferActive_reg <= 1'b0;
            end
        end
    end

    // Transmit buffer loads only from the engine, one byte pair per cycle.
    always @(posedge core_clk)
    begin : fbuf_write
        integer k;
        if (!rst_n)
        begin
            for (k = 0; k < `CSB_BLOCK_BYTES; k = k + 1)
            begin
                fBufA[k] <= 8'h00;
                fBufB[k] <= 8'h00;
            end
        end
        else if (xferActive_reg)
        begin
            // Professional block: last byte is the check byte.
            fBufA[xferIdx_reg] <= (xferIdx_reg == `CSB_LAST_BYTE && eBufA[0][7])
                                  ? crcA_reg : eBufA[xferIdx_reg];
            fBufB[xferIdx_reg] <= (xferIdx_reg == `CSB_LAST_BYTE && eBufB[0][7])
                                  ? crcB_reg : eBufB[xferIdx_reg];
        end
    end

endmodule // csb_block_buffer

`default_nettype wire

// file: csb_block_buffer_assertions.sv
// Port checker for the channel status block buffer.
// Assumes it is bound to csb_block_buffer and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.vh"
////////////////////////////////////////////////////////////
module csb_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [6:0] regAddr,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    input wire logic       subframeStrobe,
    input wire logic       txStatusBit,
    input wire logic       txStatusBitIsB,
    input wire logic       block_start_sync_direction,
    input wire logic       blockStartSyncOut,
    input wire logic       blockStartSyncOe
);
    // One clock domain, so the clock and reset are given once.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_read_answer: assert property (regRead |=> regRdValid)
        else $error("read not answered next cycle");
    chk_rd_idle: assert property (!regRead |=> !regRdValid && regRdData == 8'h00)
        else $error("read data without a read");
    // Unmapped space above the buffer window must read as zero.
    chk_unmapped_zero: assert property (
        regRead && regAddr >= `CSB_EBUF_END |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    // The serial status bit may only move on a subframe.
    chk_tx_holds: assert property (
        !subframeStrobe |=> $stable(txStatusBit) && $stable(txStatusBitIsB))
        else $error("status bit moved without strobe");
    // The strap passes two sync stages and one register.
    chk_oe_strap: assert property (
        blockStartSyncOe |-> $past(block_start_sync_direction, 3))
        else $error("sync pin driven without strap");
    chk_out_quiet: assert property (!blockStartSyncOe |-> !blockStartSyncOut)
        else $error("sync drive while listening");
    chk_sync_edges: assert property (
        blockStartSyncOe && $past(blockStartSyncOe) && $changed(blockStartSyncOut)
        |-> $past(subframeStrobe))
        else $error("sync edge off a subframe");
    // Subframes are over 30 clocks apart, so a real pulse is long.
    chk_sync_width: assert property (
        $rose(blockStartSyncOut) |-> blockStartSyncOut [*8])
        else $error("sync pulse too short");
endmodule // csb_chk

bind csb_block_buffer csb_chk chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
    .regRdData(regRdData), .regRdValid(regRdValid), .subframeStrobe(subframeStrobe),
    .txStatusBit(txStatusBit), .txStatusBitIsB(txStatusBitIsB),
    .block_start_sync_direction(block_start_sync_direction),
    .blockStartSyncOut(blockStartSyncOut), .blockStartSyncOe(blockStartSyncOe)
);
`default_nettype wire

// file: csb_host_model.sv
// Host model on the register port of the block buffer.
// Assumes tasks are called from one process at a time.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module csb_host_model (
    input wire logic       core_clk,
    input wire logic       regWrReady,
    input wire logic [7:0] regRdData,
    output var logic [6:0] regAddr,
    output var logic [7:0] regWrData,
    output var logic       regWrite,
    output var logic       regRead
);
    // Idle bus from time zero.
    initial
    begin
        regAddr = 7'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // Writes cnt bytes at a, a+2, ... with data d, d+1, ...
    // Write stays raised, so the queue can be pushed until it refuses.
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int cnt);
        int k;
        int n;
        k = 0;
        n = 0;
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        while (k < cnt && n < 300)
        begin
            @(posedge core_clk);
            n++;
            // Taken only at an edge that saw ready.
            if (regWrReady)
            begin
                k++;
                regAddr <= a + 7'(2 * k);
                regWrData <= d + 8'(k);
            end
        end
        regWrite <= 1'b0;
        if (k < cnt)
            tb_top.miscompares++;
    endtask

    // One read; data is taken one cycle after the request edge.
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(posedge core_clk);
        d = regRdData;
    endtask
endmodule // csb_host_model
`default_nettype wire

// file: tb_top.sv
// Testbench for the channel status block buffer.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.vh"
////////////////////////////////////////////////////////////
module tb_top;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;        // Shared reset, released on one edge.
    logic       subframeStrobe = 1'b0;
    logic       strap = 1'b1;        // This device drives the sync pin.
    logic       syncIn = 1'b0;       // No other party drives the pin.
    logic       pinMode = 1'b0;
    logic       serIn = 1'b0;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, rdv;
    logic       regWrite, regRead, regWrReady, regRdValid;
    logic       txStatusBit, txStatusBitIsB, xferIrq, syncOut, syncOe;
    logic [4:0] cyc = 5'h00;         // Subframe spacing of 32 clocks.
    logic       sD = 1'b0;
    logic       sawFull = 1'b0;
    logic [7:0] rec [2][24];         // Received stream, by lane and byte.
    int         sIdx = 0;
    int         blk = 0;
    int         miscompares = 0;
    int         cmp_count = 0;

    csb_host_model host_u (.core_clk(core_clk), .regWrReady(regWrReady),
        .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead));

    csb_block_buffer #(.FIFO_DEPTH(8)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regWrReady(regWrReady), .regRead(regRead), .regRdData(regRdData),
        .regRdValid(regRdValid), .subframeStrobe(subframeStrobe),
        .txStatusBit(txStatusBit), .txStatusBitIsB(txStatusBitIsB), .xferIrq(xferIrq),
        .block_start_sync_direction(strap), .blockStartSyncIn(syncIn),
        .blockStartSyncOut(syncOut), .blockStartSyncOe(syncOe),
        .pinConfigMode(pinMode), .serialStatusIn(serIn));

    ////////////////////////////////////////////////////////////
    // 20 MHz clock.
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    // Strobe generator and stream recorder; a bit is taken the cycle
    // after its strobe, when the registered output has settled.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 5'h01;
        subframeStrobe <= rst_n && cyc == 5'h1f;
        sD <= subframeStrobe;
        if (!regWrReady && rst_n)
            sawFull <= 1'b1;
        if (sD)
        begin
            check(txStatusBitIsB, sIdx % 2);
            rec[sIdx % 2][sIdx / 16][7 - (sIdx / 2) % 8] <= txStatusBit;
            sIdx <= (sIdx == 383) ? 0 : sIdx + 1;
            if (sIdx == 383)
                blk <= blk + 1;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Check byte over byte 0 = b0 then 22 zero bytes, MSB first.
    function automatic logic [7:0] crc8(input logic [7:0] b0);
        logic [7:0] c;
        c = 8'hff;
        for (int k = 0; k < 23; k++)
            for (int i = 7; i >= 0; i--)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ (k == 0 ? b0[i] : 1'b0)) ? 8'h1d : 8'h00);
        return c;
    endfunction

    // The block sent must be the first transfer, whole.
    task automatic check_block;
        for (int k = 0; k < 24; k++)
        begin
            check(rec[0][k], k == 0 ? 8'h80 : k == 23 ? crc8(8'h80) : 8'h00);
            check(rec[1][k], k == 0 ? 8'h5a : 8'h00);
        end
    endtask

    // Waits until the write queue reports empty.
    task automatic drain;
        rdv = 8'h00;
        for (int n = 0; n < 40 && rdv[1] !== 1'b1; n++)
            host_u.rd(`CSB_STAT_ADDR, rdv);
        check(rdv[1], 1'b1);
    endtask

    task tally_and_finish;
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Watchdog: three blocks take about 37000 clocks.
    initial
    begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        tally_and_finish;
    end

    // Main sequence.
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        host_u.wr(`CSB_EBUF_BASE, 8'h80, 1);
        host_u.wr(7'h21, 8'h5a, 1);
        host_u.wr(`CSB_CTRL_ADDR, 8'h02, 1);
        drain;
        host_u.rd(7'h20, rdv);
        check(rdv, 8'h80);
        host_u.rd(7'h21, rdv);
        check(rdv, 8'h5a);
        host_u.rd(7'h7f, rdv);
        check(rdv, 8'h00);
        host_u.rd(`CSB_CTRL_ADDR, rdv);
        check(rdv, 8'h02);
        host_u.rd(`CSB_STAT_ADDR, rdv);
        check(rdv, 8'h02);
        // Burst right after the transfer starts, while the queue is stalled.
        wait (blk == 1);
        host_u.wr(7'h22, 8'h01, 10);
        check(sawFull, 1'b1);
        drain;
        host_u.rd(`CSB_STAT_ADDR, rdv);
        check(rdv, 8'h03);
        check(xferIrq, 1'b1);
        host_u.rd(7'h34, rdv);
        check(rdv, 8'h0a);
        host_u.wr(`CSB_STAT_ADDR, 8'h01, 1);
        host_u.wr(`CSB_CTRL_ADDR, 8'h03, 1);
        host_u.wr(`CSB_EBUF_BASE, 8'h00, 1);
        drain;
        host_u.rd(`CSB_STAT_ADDR, rdv);
        check(rdv, 8'h02);
        check(xferIrq, 1'b0);
        wait (blk == 2);
        check_block;
        // With transfers held off, the next block repeats the old one.
        wait (blk == 3);
        check_block;
        host_u.rd(`CSB_STAT_ADDR, rdv);
        check(rdv, 8'h02);
        // Listen on the sync pin and restart mid-block.
        strap <= 1'b0;
        wait (sIdx == 20);
        syncIn <= 1'b1;
        repeat (4) @(posedge core_clk);
        syncIn <= 1'b0;
        wait (sIdx == 21);
        check(rec[0][1][5], 1'b1);
        check(syncOe, 1'b0);
        // Serial bits for B then A enter the host buffer.
        pinMode <= 1'b1;
        serIn <= 1'b1;
        wait (sIdx == 23);
        pinMode <= 1'b0;
        host_u.rd(`CSB_EBUF_BASE, rdv);
        check(rdv, 8'h40);
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
